// ==== hw/drive_output_signal_selector.sv ====
// Notes on behaviour
// - Overload warning flag is high while output current exceeds the notice level.
// - Notice level is a percentage of rated current, limited to 10 to 200.
// - Overload comparison runs in both driving and regenerative braking.
// - Relay one selector value 3 routes the overload warning flag.
// - PID deviation flag is high when setpoint-feedback magnitude exceeds its level.
// - Fault alarm function follows the drive fault condition.
// - Contact form 0 is normally open, 1 inverts to normally closed.
// - Relay one values 7, 8, 9 route overload, underload, and either.
// - Write to 0x1001 sets relays from low byte bits; high byte reserved.
// - System overload flag is high when load exceeds its level, 20 to 200.
// - System underload flag is high when load drops below its own level.
// - Load mode 1, 4 or 6 enables overload detection; 4, 6 report faults.
// - Load mode 2, 5 or 6 enables underload detection; 5, 6 report faults.
// - Combined function checks overload and underload levels independently.
// - Meter source selector picks frequency, current, voltage, power, torque, communication.
// - Frequency source reaches full scale at the maximum frequency.
// - Current source reaches full scale at twice rated current.
// - Voltage full scale is rated voltage; power full scale is twice rated.
// - Torque maps minus 150 percent to zero, zero to half, plus 150 to full.
// - Write of 0 to 10000 at 0x1004 sets the meter when source is 5.
// - Meter gain 0.0 to 250.0 percent in 0.1 steps multiplies the output.
// - Meter offset -3.0 to 10.0 percent in 0.1 steps is added.
`timescale 1ns/10ps
`default_nettype none
`include "dos_map.svh"
module drive_output_signal_selector
   import dos_pkg::*;
#(
   parameter int NUM_RELAY = 3,
   parameter int NUM_FN = 10,
   parameter int CODE_W = 14
) (
   // ************************************************************
   // Clock, reset, enable
   // ************************************************************
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // ************************************************************
   // Drive status, levels in 0.1 percent
   // ************************************************************
   input wire logic motor_running_i,
   input wire logic regen_braking_i,
   input wire logic freq_arrival1_i,
   input wire logic freq_arrival2_i,
   input wire logic drive_fault_i,
   input wire logic [15:0] output_current_i,
   input wire logic [15:0] system_load_i,
   input wire logic [15:0] pid_setpoint_i,
   input wire logic [15:0] pid_feedback_i,
   input wire logic [15:0] output_freq_i,
   input wire logic [15:0] max_freq_i,
   input wire logic [15:0] output_voltage_i,
   input wire logic [15:0] output_power_i,
   input wire logic signed [15:0] output_torque_i,
   // ************************************************************
   // Parameter settings
   // ************************************************************
   input wire dos_relay_fn_t relay1_function_select_i,
   input wire dos_relay_fn_t relay2_function_select_i,
   input wire dos_relay_fn_t relay3_function_select_i,
   input wire logic [NUM_RELAY-1:0] relay_contact_form_select_i,
   input wire logic [15:0] overload_notice_level_i,
   input wire logic [15:0] pid_deviation_level_i,
   input wire dos_load_mode_t load_detect_mode_i,
   input wire logic [15:0] system_overload_level_i,
   input wire logic [15:0] system_underload_level_i,
   input wire dos_meter_src_t meter_source_select_i,
   input wire logic [15:0] meter_gain_i,
   input wire logic signed [15:0] meter_offset_i,
   // ************************************************************
   // Modbus register writes
   // ************************************************************
   input wire logic mb_wr_i,
   input wire logic [15:0] mb_addr_i,
   input wire logic [15:0] mb_data_i,
   // ************************************************************
   // Flags, fault codes, contacts, meter
   // ************************************************************
   output logic overload_warning_flag_o,
   output logic pid_deviation_flag_o,
   output logic fault_alarm_flag_o,
   output logic system_overload_flag_o,
   output logic system_underload_flag_o,
   output logic overload_fault_code_o,
   output logic underload_fault_code_o,
   output logic relay_one_contacts_o,
   output logic relay_two_contacts_o,
   output logic relay_three_contacts_o,
   output logic [CODE_W-1:0] meter_voltage_output_o
);
   // ************************************************************
   // Settings limited to their legal ranges
   // ************************************************************
   logic [15:0] ol_lvl;
   logic [15:0] pid_lvl;
   logic [15:0] sov_lvl;
   logic [15:0] sud_lvl;
   logic [15:0] gain_lim;
   logic signed [15:0] off_lim;
   logic [15:0] pid_err;
   dos_relay_fn_t relay_sel [NUM_RELAY];

   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] lo,
                                       input logic [15:0] hi);
      lim = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   always_comb begin
      ol_lvl = lim(overload_notice_level_i, `DOS_OLN_MIN, `DOS_OLN_MAX);
      pid_lvl = lim(pid_deviation_level_i, 16'h0000, `DOS_PID_MAX);
      sov_lvl = lim(system_overload_level_i, `DOS_SYS_MIN, `DOS_SYS_MAX);
      sud_lvl = lim(system_underload_level_i, `DOS_SYS_MIN, `DOS_SYS_MAX);
      gain_lim = lim(meter_gain_i, 16'h0000, `DOS_GAIN_MAX);
      off_lim = meter_offset_i;
      if (meter_offset_i < $signed(`DOS_OFF_MIN)) begin
         off_lim = $signed(`DOS_OFF_MIN);
      end else if (meter_offset_i > $signed(`DOS_OFF_MAX)) begin
         off_lim = $signed(`DOS_OFF_MAX);
      end
      pid_err = (pid_setpoint_i > pid_feedback_i) ? pid_setpoint_i - pid_feedback_i
                                                  : pid_feedback_i - pid_setpoint_i;
      relay_sel[0] = relay1_function_select_i;
      relay_sel[1] = relay2_function_select_i;
      relay_sel[2] = relay3_function_select_i;
   end

   // ************************************************************
   // Condition flags
   // ************************************************************
   logic ol_reg, ol_next, od_reg, od_next, al_reg, al_next;
   logic sod_reg, sod_next, sud_reg, sud_next;
   logic ofc_reg, ofc_next, ufc_reg, ufc_next;
   logic over_en, under_en;

   always_comb begin
      // Regeneration does not gate the comparison: braking can overload too.
      ol_next = output_current_i > ol_lvl;
      od_next = pid_err > pid_lvl;
      al_next = drive_fault_i;
      over_en = (load_detect_mode_i == DOS_LD_OVER) ||
                (load_detect_mode_i == DOS_LD_OVER_FLT) ||
                (load_detect_mode_i == DOS_LD_BOTH_FLT);
      under_en = (load_detect_mode_i == DOS_LD_UNDER) ||
                 (load_detect_mode_i == DOS_LD_UNDER_FLT) ||
                 (load_detect_mode_i == DOS_LD_BOTH_FLT);
      sod_next = over_en && (system_load_i > sov_lvl);
      sud_next = under_en && (system_load_i < sud_lvl);
      ofc_next = sod_next && (load_detect_mode_i != DOS_LD_OVER);
      ufc_next = sud_next && (load_detect_mode_i != DOS_LD_UNDER);
   end

   // ************************************************************
   // Modbus words
   // ************************************************************
   logic [NUM_RELAY-1:0] comm_reg, comm_next;
   logic [15:0] mcomm_reg, mcomm_next;

   always_comb begin
      comm_next = comm_reg;
      mcomm_next = mcomm_reg;
      if (mb_wr_i && (mb_addr_i == `DOS_ADDR_RELAY)) begin
         // High byte is reserved and dropped.
         comm_next[0] = mb_data_i[`DOS_BIT_RELAY1];
         comm_next[1] = mb_data_i[`DOS_BIT_RELAY2];
         comm_next[2] = mb_data_i[`DOS_BIT_RELAY3];
      end
      if (mb_wr_i && (mb_addr_i == `DOS_ADDR_METER) &&
          (meter_source_select_i == DOS_SRC_COMM)) begin
         mcomm_next = mb_data_i;
      end
   end

   // ************************************************************
   // Relay routing
   // ************************************************************
   logic [NUM_RELAY-1:0] relay_next;
   logic [NUM_RELAY-1:0] relay_reg;

   // Routing uses the next flag values so a contact and its flag change together.
   for (genvar r = 0; r < NUM_RELAY; r++) begin : g_relay
      dos_relay_mux #(
         .NUM_FN(NUM_FN)
      ) u_mux (
         .fn_flags_i({sod_next | sud_next, sud_next, sod_next, comm_next[r], al_next,
                      od_next, ol_next, freq_arrival2_i, freq_arrival1_i,
                      motor_running_i}),
         .sel_i(relay_sel[r]),
         .form_i(relay_contact_form_select_i[r]),
         .drive_o(relay_next[r])
      );
   end

   // ************************************************************
   // Meter
   // ************************************************************
   logic [CODE_W-1:0] meter_next, meter_reg;

   dos_meter_scale #(
      .CODE_W(CODE_W)
   ) u_meter (
      .src_i(meter_source_select_i),
      .freq_i(output_freq_i),
      .max_freq_i(max_freq_i),
      .current_i(output_current_i),
      .voltage_i(output_voltage_i),
      .power_i(output_power_i),
      .torque_i(output_torque_i),
      .comm_value_i(mcomm_reg),
      .gain_i(gain_lim),
      .offset_i(off_lim),
      .code_o(meter_next)
   );

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ol_reg <= 1'b0;
         od_reg <= 1'b0;
         al_reg <= 1'b0;
         sod_reg <= 1'b0;
         sud_reg <= 1'b0;
         ofc_reg <= 1'b0;
         ufc_reg <= 1'b0;
         comm_reg <= '0;
         mcomm_reg <= 16'h0000;
         relay_reg <= relay_contact_form_select_i & '0;
         meter_reg <= '0;
      end else if (clk_en_i) begin
         ol_reg <= ol_next;
         od_reg <= od_next;
         al_reg <= al_next;
         sod_reg <= sod_next;
         sud_reg <= sud_next;
         ofc_reg <= ofc_next;
         ufc_reg <= ufc_next;
         comm_reg <= comm_next;
         mcomm_reg <= mcomm_next;
         relay_reg <= relay_next;
         meter_reg <= meter_next;
      end
   end

   assign overload_warning_flag_o = ol_reg;
   assign pid_deviation_flag_o = od_reg;
   assign fault_alarm_flag_o = al_reg;
   assign system_overload_flag_o = sod_reg;
   assign system_underload_flag_o = sud_reg;
   assign overload_fault_code_o = ofc_reg;
   assign underload_fault_code_o = ufc_reg;
   assign relay_one_contacts_o = relay_reg[0];
   assign relay_two_contacts_o = relay_reg[1];
   assign relay_three_contacts_o = relay_reg[2];
   assign meter_voltage_output_o = meter_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_ol_on_excess: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (output_current_i > ol_lvl)) |=> overload_warning_flag_o)
      else $error("Overload warning missed.");
   a_ol_regen_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && regen_braking_i && (output_current_i <= ol_lvl))
      |=> !overload_warning_flag_o)
      else $error("Overload warning false during braking.");
   a_relay_ol_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (relay1_function_select_i == DOS_FN_OL) &&
       !relay_contact_form_select_i[0])
      |=> (relay_one_contacts_o == overload_warning_flag_o))
      else $error("Relay one not following overload warning.");
   a_pid_on_excess: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (pid_err > pid_lvl)) |=> pid_deviation_flag_o)
      else $error("PID deviation missed.");
   a_alarm_follows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      clk_en_i |=> (fault_alarm_flag_o == $past(drive_fault_i)))
      else $error("Fault alarm not following fault.");
   a_form_b_invert: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (relay1_function_select_i == DOS_FN_AL) &&
       relay_contact_form_select_i[0])
      |=> (relay_one_contacts_o == !fault_alarm_flag_o))
      else $error("Normally closed contact not inverted.");
   a_relay_either: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (relay1_function_select_i == DOS_FN_SOD_SUD) &&
       !relay_contact_form_select_i[0])
      |=> (relay_one_contacts_o == (system_overload_flag_o | system_underload_flag_o)))
      else $error("Relay one not following combined load flag.");
   a_comm_relay_bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && mb_wr_i && (mb_addr_i == `DOS_ADDR_RELAY) &&
       (relay1_function_select_i == DOS_FN_COM) && !relay_contact_form_select_i[0])
      |=> (relay_one_contacts_o == $past(mb_data_i[`DOS_BIT_RELAY1])))
      else $error("Relay one not set by communication word.");
   a_sod_mode_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (load_detect_mode_i == DOS_LD_UNDER))
      |=> (!system_overload_flag_o && !overload_fault_code_o))
      else $error("Overload detected while disabled.");
   a_sud_fault_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (load_detect_mode_i == DOS_LD_BOTH_FLT) && (system_load_i < sud_lvl))
      |=> (system_underload_flag_o && underload_fault_code_o))
      else $error("Underload fault code missed.");
   a_meter_comm_pass: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      (clk_en_i && (meter_source_select_i == DOS_SRC_COMM) &&
       (meter_gain_i == `DOS_GAIN_RST) && (meter_offset_i == 16'sh0000) &&
       ($signed({16'h0000, mcomm_reg}) <= `DOS_METER_FULL))
      |=> (meter_voltage_output_o == $past(mcomm_reg[CODE_W-1:0])))
      else $error("Meter not equal to written value.");
   a_meter_clamped: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $signed({18'h00000, meter_voltage_output_o}) <= `DOS_METER_FULL)
      else $error("Meter code above full scale.");
endmodule
`default_nettype wire

// ==== hw/dos_map.svh ====
`ifndef DOS_MAP_SVH
`define DOS_MAP_SVH
// ************************************************************
// Modbus word addresses
// ************************************************************
`define DOS_ADDR_RELAY 16'h1001
`define DOS_ADDR_METER 16'h1004
// ************************************************************
// Relay word bit positions, low byte
// ************************************************************
`define DOS_BIT_RELAY2 3'h0
`define DOS_BIT_RELAY3 3'h1
`define DOS_BIT_RELAY1 3'h2
// ************************************************************
// Setting limits, all in 0.1 percent
// ************************************************************
`define DOS_OLN_MIN 16'h0064
`define DOS_OLN_MAX 16'h07d0
`define DOS_PID_MAX 16'h03e8
`define DOS_SYS_MIN 16'h00c8
`define DOS_SYS_MAX 16'h07d0
`define DOS_GAIN_MAX 16'h09c4
`define DOS_OFF_MIN 16'hffe2
`define DOS_OFF_MAX 16'h0064
// ************************************************************
// Meter scaling
// ************************************************************
`define DOS_METER_FULL 32'sh0000_2710
`define DOS_CUR_FS 32'sh0000_07d0
`define DOS_VOLT_FS 32'sh0000_03e8
`define DOS_POW_FS 32'sh0000_07d0
`define DOS_TRQ_FS 32'sh0000_05dc
`define DOS_TRQ_SPAN 32'sh0000_0bb8
`define DOS_UNIT 32'sh0000_03e8
`define DOS_GAIN_RST 16'h03e8
`endif

// ==== hw/dos_pkg.sv ====
`default_nettype none
package dos_pkg;
   typedef enum logic [3:0] {
      DOS_FN_RUN = 4'h0, DOS_FN_FA1 = 4'h1, DOS_FN_FA2 = 4'h2,
      DOS_FN_OL = 4'h3, DOS_FN_OD = 4'h4, DOS_FN_AL = 4'h5,
      DOS_FN_COM = 4'h6, DOS_FN_SOD = 4'h7, DOS_FN_SUD = 4'h8,
      DOS_FN_SOD_SUD = 4'h9
   } dos_relay_fn_t;
   typedef enum logic [2:0] {
      DOS_SRC_FREQ = 3'h0, DOS_SRC_CUR = 3'h1, DOS_SRC_VOLT = 3'h2,
      DOS_SRC_POW = 3'h3, DOS_SRC_TRQ = 3'h4, DOS_SRC_COMM = 3'h5
   } dos_meter_src_t;
   typedef enum logic [2:0] {
      DOS_LD_OFF = 3'h0, DOS_LD_OVER = 3'h1, DOS_LD_UNDER = 3'h2,
      DOS_LD_RSVD = 3'h3, DOS_LD_OVER_FLT = 3'h4, DOS_LD_UNDER_FLT = 3'h5,
      DOS_LD_BOTH_FLT = 3'h6
   } dos_load_mode_t;
endpackage
`default_nettype wire

// ==== hw/dos_relay_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
module dos_relay_mux
   import dos_pkg::*;
#(
   parameter int NUM_FN = 10
) (
   // Function flags and selection
   input wire logic [NUM_FN-1:0] fn_flags_i,
   input wire dos_relay_fn_t sel_i,
   input wire logic form_i,
   // Contact drive
   output logic drive_o
);
   logic active;

   always_comb begin
      active = 1'b0;
      // Selector codes with no function leave the contact idle.
      if (int'(sel_i) < NUM_FN) begin
         active = fn_flags_i[sel_i];
      end
      drive_o = active ^ form_i;
   end
endmodule
`default_nettype wire

// ==== hw/dos_meter_scale.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dos_map.svh"
module dos_meter_scale
   import dos_pkg::*;
#(
   parameter int CODE_W = 14
) (
   // Source selection and quantities
   input wire dos_meter_src_t src_i,
   input wire logic [15:0] freq_i,
   input wire logic [15:0] max_freq_i,
   input wire logic [15:0] current_i,
   input wire logic [15:0] voltage_i,
   input wire logic [15:0] power_i,
   input wire logic signed [15:0] torque_i,
   input wire logic [15:0] comm_value_i,
   // Adjustment
   input wire logic [15:0] gain_i,
   input wire logic signed [15:0] offset_i,
   // Meter code
   output logic [CODE_W-1:0] code_o
);
   logic signed [31:0] raw;
   logic signed [31:0] adj;

   always_comb begin
      raw = 32'sh0;
      case (src_i)
         DOS_SRC_FREQ: begin
            if (max_freq_i != 16'h0000) begin
               raw = ($signed({16'h0000, freq_i}) * `DOS_METER_FULL) /
                     $signed({16'h0000, max_freq_i});
            end
         end
         DOS_SRC_CUR: raw = ($signed({16'h0000, current_i}) * `DOS_METER_FULL)
                            / `DOS_CUR_FS;
         DOS_SRC_VOLT: raw = ($signed({16'h0000, voltage_i}) * `DOS_METER_FULL)
                             / `DOS_VOLT_FS;
         DOS_SRC_POW: raw = ($signed({16'h0000, power_i}) * `DOS_METER_FULL)
                            / `DOS_POW_FS;
         DOS_SRC_TRQ: raw = (($signed({{16{torque_i[15]}}, torque_i}) + `DOS_TRQ_FS)
                             * `DOS_METER_FULL) / `DOS_TRQ_SPAN;
         DOS_SRC_COMM: raw = $signed({16'h0000, comm_value_i});
         default: raw = 32'sh0;
      endcase
      // Gain first, then offset, so the offset is not scaled by the gain.
      adj = (raw * $signed({16'h0000, gain_i})) / `DOS_UNIT;
      adj = adj + ($signed({{16{offset_i[15]}}, offset_i}) * `DOS_METER_FULL)
            / `DOS_UNIT;
      if (adj < 32'sh0) begin
         adj = 32'sh0;
      end else if (adj > `DOS_METER_FULL) begin
         adj = `DOS_METER_FULL;
      end
      code_o = adj[CODE_W-1:0];
   end
endmodule
`default_nettype wire

// ==== dv/dos_mb_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module dos_mb_master (
   // Clock
   input wire logic clk_i,
   // Register writes
   output logic mb_wr_o,
   output logic [15:0] mb_addr_o,
   output logic [15:0] mb_data_o
);
   // ************************************************************
   // Remote master
   // ************************************************************
   initial begin
      mb_wr_o = 1'b0;
      mb_addr_o = 16'h0000;
      mb_data_o = 16'h0000;
   end
   // One word per call with no acknowledge, so the strobe stands one edge only.
   task automatic write_word(input logic [15:0] addr, input logic [15:0] data);
      @(posedge clk_i);
      #1;
      mb_wr_o = 1'b1;
      mb_addr_o = addr;
      mb_data_o = data;
      @(posedge clk_i);
      #1;
      // A released bus shows the inverse, so a stale word never looks live.
      mb_wr_o = 1'b0;
      mb_addr_o = ~addr;
      mb_data_o = ~data;
   endtask
endmodule
`default_nettype wire

// ==== dv/drive_output_signal_selector_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module drive_output_signal_selector_tb_top
   import dos_pkg::*;
;
   localparam logic [9:0] FN_EXP = 10'h2ad;
   localparam logic [13:0] M_EXP [6] = '{14'h1388, 14'h09c4, 14'h1f40, 14'h01f4,
      14'h1770, 14'h1388};
   int n_tests = 0;
   int bad_count = 0;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, run = 1'b0, regen = 1'b0, fa1 = 1'b0;
   logic fa2 = 1'b0, fault = 1'b0;
   logic [15:0] cur = '0, load = '0, sp = '0, fb = '0, freq = '0, fmax = '0, volt = '0;
   logic [15:0] pow = '0, oln = '0, pidl = '0, sol = '0, sul = '0, gain = '0;
   logic signed [15:0] trq = '0, off = '0;
   dos_relay_fn_t s1 = DOS_FN_RUN, s2 = DOS_FN_RUN, s3 = DOS_FN_RUN;
   logic [2:0] form = 3'h0;
   dos_load_mode_t mode = DOS_LD_OFF;
   dos_meter_src_t src = DOS_SRC_FREQ;
   logic mb_wr;
   logic [15:0] mb_addr, mb_data;
   logic warn_f, dev_f, alarm_f, s_over, s_under, c_over, c_under, r1, r2, r3;
   logic [13:0] meter;
   always #25 clk = ~clk;
   dos_mb_master dos_mb_master_i (.clk_i(clk), .mb_wr_o(mb_wr), .mb_addr_o(mb_addr),
      .mb_data_o(mb_data));
   drive_output_signal_selector drive_output_signal_selector_i (
      .clk_sys_i(clk), .sys_rst_i(rst), .clk_en_i(en), .motor_running_i(run),
      .regen_braking_i(regen), .freq_arrival1_i(fa1), .freq_arrival2_i(fa2),
      .drive_fault_i(fault), .output_current_i(cur), .system_load_i(load),
      .pid_setpoint_i(sp), .pid_feedback_i(fb), .output_freq_i(freq), .max_freq_i(fmax),
      .output_voltage_i(volt), .output_power_i(pow), .output_torque_i(trq),
      .relay1_function_select_i(s1), .relay2_function_select_i(s2),
      .relay3_function_select_i(s3), .relay_contact_form_select_i(form),
      .overload_notice_level_i(oln), .pid_deviation_level_i(pidl),
      .load_detect_mode_i(mode), .system_overload_level_i(sol),
      .system_underload_level_i(sul), .meter_source_select_i(src), .meter_gain_i(gain),
      .meter_offset_i(off), .mb_wr_i(mb_wr), .mb_addr_i(mb_addr), .mb_data_i(mb_data),
      .overload_warning_flag_o(warn_f), .pid_deviation_flag_o(dev_f),
      .fault_alarm_flag_o(alarm_f), .system_overload_flag_o(s_over),
      .system_underload_flag_o(s_under), .overload_fault_code_o(c_over),
      .underload_fault_code_o(c_under), .relay_one_contacts_o(r1),
      .relay_two_contacts_o(r2), .relay_three_contacts_o(r3), .meter_voltage_output_o(meter));
   // ************************************************************
   // Helpers
   // ************************************************************
   // Three edges cover the two-edge meter path with margin.
   task automatic step();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      `CHK("relays_rst", 3'h0, {r1, r2, r3})
      run = 1'b1;
      fa2 = 1'b1;
      fault = 1'b1;
      cur = 16'h0400;
      oln = 16'h03e8;
      regen = 1'b1;
      load = 16'h0800;
      sol = 16'h07d0;
      sul = 16'h00c8;
      mode = DOS_LD_BOTH_FLT;
      for (int k = 0; k < 20; k++) begin
         s1 = dos_relay_fn_t'(k % 10);
         form = {2'h0, k >= 10};
         step();
         `CHK("relay_fn", FN_EXP[k % 10] ^ (k >= 10), r1)
      end
      `CHK("flags_drive", 3'h5, {warn_f, dev_f, alarm_f})
      `CHK("flags_load", 4'ha, {s_over, s_under, c_over, c_under})
      s1 = DOS_FN_SOD_SUD;
      form = 3'h0;
      load = 16'h0064;
      step();
      `CHK("under_both", 5'h15, {r1, s_over, s_under, c_over, c_under})
      mode = DOS_LD_OVER;
      step();
      `CHK("under_off", 3'h0, {r1, s_under, c_under})
      load = 16'h0800;
      step();
      `CHK("over_nofault", 3'h6, {r1, s_over, c_over})
      mode = DOS_LD_UNDER;
      step();
      `CHK("over_off", 1'b0, s_over)
      mode = DOS_LD_OVER_FLT;
      step();
      `CHK("over_flt", 2'h3, {s_over, c_over})
      mode = DOS_LD_UNDER_FLT;
      load = 16'h0064;
      step();
      `CHK("under_flt", 4'h5, {s_over, s_under, c_over, c_under})
      mode = DOS_LD_RSVD;
      step();
      `CHK("mode_none", 2'h0, {s_under, c_under})
      mode = DOS_LD_OFF;
      load = 16'h0800;
      step();
      `CHK("mode_off", 2'h0, {s_over, c_over})
      s1 = DOS_FN_OL;
      regen = 1'b0;
      cur = 16'h03e8;
      step();
      `CHK("warn_equal", 2'h0, {warn_f, r1})
      regen = 1'b1;
      cur = 16'h0050;
      oln = 16'h0032;
      step();
      `CHK("warn_clamp", 2'h0, {warn_f, r1})
      cur = 16'h0065;
      step();
      `CHK("warn_regen", 2'h3, {warn_f, r1})
      s1 = DOS_FN_OD;
      pidl = 16'h0064;
      sp = 16'h012c;
      fb = 16'h01f4;
      step();
      `CHK("dev_high", 2'h3, {dev_f, r1})
      sp = 16'h01c2;
      step();
      `CHK("dev_low", 2'h0, {dev_f, r1})
      s1 = DOS_FN_COM;
      s2 = DOS_FN_COM;
      s3 = DOS_FN_COM;
      form = 3'h4;
      dos_mb_master_i.write_word(16'h1001, 16'h0005);
      step();
      `CHK("comm_relays", 3'h7, {r1, r2, r3})
      dos_mb_master_i.write_word(16'h1001, 16'hff02);
      step();
      `CHK("comm_rsvd", 3'h0, {r1, r2, r3})
      dos_mb_master_i.write_word(16'h1002, 16'h0007);
      step();
      `CHK("comm_addr", 3'h0, {r1, r2, r3})
      gain = 16'h03e8;
      src = DOS_SRC_COMM;
      dos_mb_master_i.write_word(16'h1004, 16'h1388);
      step();
      src = DOS_SRC_FREQ;
      dos_mb_master_i.write_word(16'h1004, 16'h0000);
      step();
      freq = 16'h0019;
      fmax = 16'h0032;
      cur = 16'h01f4;
      volt = 16'h0320;
      pow = 16'h0064;
      trq = 16'sh012c;
      for (int k = 0; k < 6; k++) begin
         src = dos_meter_src_t'(k);
         step();
         `CHK("meter_src", M_EXP[k], meter)
      end
      src = DOS_SRC_TRQ;
      trq = 16'shfa24;
      step();
      `CHK("torque_min", 14'h0000, meter)
      trq = 16'sh05dc;
      step();
      `CHK("torque_max", 14'h2710, meter)
      src = DOS_SRC_CUR;
      gain = 16'h07d0;
      off = 16'sh0064;
      step();
      `CHK("gain_off", 14'h1770, meter)
      gain = 16'h0fa0;
      step();
      `CHK("gain_clamp", 14'h1c52, meter)
      gain = 16'h0000;
      off = 16'shffe2;
      step();
      `CHK("meter_low", 14'h0000, meter)
      cur = 16'h07d0;
      gain = 16'h09c4;
      off = 16'sh0064;
      step();
      `CHK("meter_high", 14'h2710, meter)
      // With the enable low every output holds and a write strobe is refused.
      en = 1'b0;
      fault = 1'b0;
      cur = 16'h0000;
      off = 16'sh00c8;
      dos_mb_master_i.write_word(16'h1001, 16'h0004);
      step();
      `CHK("en_alarm", 1'b1, alarm_f)
      `CHK("en_meter", 14'h2710, meter)
      en = 1'b1;
      step();
      `CHK("en_resume", 2'h0, {alarm_f, r1})
      `CHK("en_offset", 14'h03e8, meter)
      dos_mb_master_i.write_word(16'h1001, 16'h0004);
      step();
      `CHK("comm_one", 1'b1, r1)
      // A reset in mid-run clears the stored relay word as well as the outputs.
      rst = 1'b1;
      fault = 1'b1;
      step();
      `CHK("rst_mid", 3'h0, {r1, alarm_f, meter != 14'h0000})
      rst = 1'b0;
      step();
      `CHK("rst_comm", 2'h1, {r1, alarm_f})
      finish_test();
   end
   // The tests need under 400 cycles; this allows five times that.
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
